// ### pmc_pkg.sv
// Purpose: shared constants and types for the power mode controller
// Assumes: one 100 MHz clock, active-low asynchronous reset
// Notes: register map belongs to the core end, reached over AHB-Lite
package pmc_pkg;
  localparam logic [7:0] PMC_PWR_CTRL_OFS = 8'h00;
  localparam logic [7:0] PMC_PWR_CTRL2_OFS = 8'h04;
  localparam logic [7:0] PMC_REG_CTRL_OFS = 8'h08;
  localparam logic [7:0] PMC_STATUS_OFS = 8'h0C;
  localparam logic [7:0] PMC_WAKE_EN_OFS = 8'h10;
  localparam logic [7:0] PMC_PERIPH_EN_OFS = 8'h14;
  localparam int PMC_IDLE_BIT = 0;
  localparam int PMC_STOP_BIT = 1;
  localparam int PMC_SUSPEND_BIT = 6;
  localparam int PMC_SNOOZE_BIT = 7;
  localparam int PMC_STOPSEL_BIT = 0;
  localparam int PMC_WAKE_W = 6;
  localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;
  localparam logic [7:0] PMC_PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] PMC_PERIPH_EN_RST = 8'h00;
  localparam int PMC_OSC_SETTLE_NS = 200;
  localparam int PMC_CLK_NS = 10;
  localparam int PMC_OSC_SETTLE_CYC = (PMC_OSC_SETTLE_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
  typedef enum logic [2:0]
  {
    PMC_NORMAL = 3'h0,
    PMC_IDLE = 3'h1,
    PMC_SUSP = 3'h3,
    PMC_WARM = 3'h2,
    PMC_SNOOZE = 3'h6,
    PMC_STOP = 3'h7,
    PMC_SHUT = 3'h5
  } pmc_state_t;
  typedef enum logic [2:0]
  {
    PMC_M_NORMAL = 3'h0,
    PMC_M_IDLE = 3'h1,
    PMC_M_SUSPEND = 3'h2,
    PMC_M_SNOOZE = 3'h3,
    PMC_M_STOP = 3'h4,
    PMC_M_SHUTDOWN = 3'h5
  } pmc_mode_t;
endpackage : pmc_pkg

// ### pmc_if.sv
// Purpose: link between the core end and the power sequencer end
// Assumes: both ends on hclk
// Notes: requests are one-cycle pulses, state outputs are levels
`timescale 1ns/100ps
`default_nettype none
interface pmc_if;
  logic idle_req;
  logic stop_req;
  logic suspend_req;
  logic snooze_req;
  logic stop_shutdown_select;
  logic [5:0] wake_en;
  logic [7:0] periph_en;
  logic cpu_halt;
  logic idle_exit;
  logic resume;
  logic [2:0] mode;
  modport core
  (
    output idle_req, stop_req, suspend_req, snooze_req, stop_shutdown_select,
    output wake_en, periph_en,
    input cpu_halt, idle_exit, resume, mode
  );
  modport seq
  (
    input idle_req, stop_req, suspend_req, snooze_req, stop_shutdown_select,
    input wake_en, periph_en,
    output cpu_halt, idle_exit, resume, mode
  );
endinterface : pmc_if
`default_nettype wire

// ### pmc_sequencer.sv
// Purpose: power mode sequencer: clocks, oscillators, regulator bias, wake
// Assumes: wake and reset-pin inputs are asynchronous and synchronised here
// Notes: stop and shutdown are left only by reset
`timescale 1ns/100ps
`default_nettype none
module pmc_sequencer #(
  parameter int SETTLE_CYC = pmc_pkg::PMC_OSC_SETTLE_CYC
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link to the core end
  pmc_if.seq lnk,
  // interrupt and reset sources
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic reset_pin_n,
  input wire logic [5:0] wake_evt,
  // power and clock controls
  output logic core_clk_en,
  output logic system_clock_en,
  output logic [7:0] periph_clk_en,
  output logic fast_internal_osc_a_en,
  output logic fast_internal_osc_b_en,
  output logic low_freq_osc_en,
  output logic timer34_lf_en,
  output logic reg_low_bias,
  output logic core_ldo_en,
  output logic vreg5_active,
  output logic sys_reset_req,
  output logic [15:0] fetch_addr
);
  // three-stage synchronisers; stage one feeds only stage two
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [6:0] s3_q;
  logic [6:0] st_q;
  logic [6:0] st_d;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // reset to the pins' idle levels so no false wake edge follows reset
      s1_q <= 7'h60;
      s2_q <= 7'h60;
      s3_q <= 7'h60;
      st_q <= 7'h60;
    end
    else
    begin
      s1_q <= {reset_pin_n, wake_evt};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end
  // a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_flt
      assign st_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : st_q[gi];
    end
  endgenerate
  logic [5:0] wake_prev_q;
  logic pin_rst;
  logic [5:0] wake_hit;
  assign pin_rst = ~st_q[6];
  // comparator 0 (bit 5) wakes on a falling edge, the others on a level
  assign wake_hit = lnk.wake_en & {~st_q[5] & wake_prev_q[5], st_q[4:0]};
  pmc_pkg::pmc_state_t state_q;
  pmc_pkg::pmc_state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic low_q;
  logic low_d;
  logic resume_d;
  logic rst_d;
  logic resume_q;
  logic rst_q;
  logic exit_d;
  logic exit_q;
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    low_d = low_q;
    resume_d = 1'b0;
    rst_d = 1'b0;
    exit_d = 1'b0;
    case (state_q)
      pmc_pkg::PMC_NORMAL:
      begin
        if (lnk.stop_req)
          state_d = lnk.stop_shutdown_select ? pmc_pkg::PMC_SHUT : pmc_pkg::PMC_STOP;
        else if (lnk.suspend_req || lnk.snooze_req)
        begin
          state_d = lnk.snooze_req ? pmc_pkg::PMC_SNOOZE : pmc_pkg::PMC_SUSP;
          low_d = lnk.snooze_req;
        end
        else if (lnk.idle_req)
          state_d = pmc_pkg::PMC_IDLE;
      end
      pmc_pkg::PMC_IDLE:
      begin
        if (irq_pending)
        begin
          state_d = pmc_pkg::PMC_NORMAL;
          resume_d = 1'b1;
          exit_d = 1'b1;
        end
      end
      pmc_pkg::PMC_SUSP, pmc_pkg::PMC_SNOOZE:
      begin
        if (|wake_hit)
        begin
          state_d = pmc_pkg::PMC_WARM;
          cnt_d = 8'(SETTLE_CYC);
          low_d = 1'b0;
        end
      end
      pmc_pkg::PMC_WARM:
      begin
        if (cnt_q <= 8'h01)
        begin
          state_d = pmc_pkg::PMC_NORMAL;
          resume_d = 1'b1;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      pmc_pkg::PMC_STOP, pmc_pkg::PMC_SHUT:
        state_d = state_q;
      default:
        state_d = pmc_pkg::PMC_NORMAL;
    endcase
    // any reset ends every mode; in shutdown only the pin counts
    if (pin_rst || (wdt_timeout && state_q != pmc_pkg::PMC_SHUT))
    begin
      state_d = pmc_pkg::PMC_NORMAL;
      rst_d = 1'b1;
      exit_d = 1'b0;
      low_d = 1'b0;
      resume_d = 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= pmc_pkg::PMC_NORMAL;
      cnt_q <= 8'h00;
      low_q <= 1'b0;
      resume_q <= 1'b0;
      rst_q <= 1'b0;
      exit_q <= 1'b0;
      wake_prev_q <= 6'h20;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      resume_q <= resume_d;
      rst_q <= rst_d;
      exit_q <= exit_d;
      wake_prev_q <= st_q[5:0];
    end
  end
  logic running;
  logic asleep;
  assign running = (state_q == pmc_pkg::PMC_NORMAL);
  assign asleep = (state_q == pmc_pkg::PMC_SUSP) || (state_q == pmc_pkg::PMC_SNOOZE);
  always_comb
  begin
    core_clk_en = running;
    system_clock_en = running || (state_q == pmc_pkg::PMC_IDLE);
    periph_clk_en = system_clock_en ? lnk.periph_en : 8'h00;
    fast_internal_osc_a_en = !asleep && (state_q != pmc_pkg::PMC_STOP)
      && (state_q != pmc_pkg::PMC_SHUT);
    fast_internal_osc_b_en = running || (state_q == pmc_pkg::PMC_IDLE);
    low_freq_osc_en = 1'b1;
    timer34_lf_en = asleep;
    reg_low_bias = low_q;
    core_ldo_en = (state_q != pmc_pkg::PMC_SHUT);
    vreg5_active = 1'b1;
    sys_reset_req = rst_q;
    fetch_addr = pmc_pkg::PMC_RESET_VECTOR;
    lnk.cpu_halt = !running;
    // only a wake from idle, not the end of a suspend warm-up
    lnk.idle_exit = exit_q;
    lnk.resume = resume_q;
  end
  always_comb
  begin
    case (state_q)
      pmc_pkg::PMC_IDLE: lnk.mode = pmc_pkg::PMC_M_IDLE;
      pmc_pkg::PMC_SUSP: lnk.mode = pmc_pkg::PMC_M_SUSPEND;
      pmc_pkg::PMC_SNOOZE: lnk.mode = pmc_pkg::PMC_M_SNOOZE;
      pmc_pkg::PMC_STOP: lnk.mode = pmc_pkg::PMC_M_STOP;
      pmc_pkg::PMC_SHUT: lnk.mode = pmc_pkg::PMC_M_SHUTDOWN;
      default: lnk.mode = pmc_pkg::PMC_M_NORMAL;
    endcase
  end
endmodule : pmc_sequencer
`default_nettype wire

// ### pmc_core_regs.sv
// Purpose: core end: power control registers on AHB-Lite, requests to sequencer
// Assumes: single word transfers, zero wait states, OKAY response
// Notes: writing a mode bit pulses the request once
`timescale 1ns/100ps
`default_nettype none
module pmc_core_regs
(
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link to the sequencer
  pmc_if.core lnk
);
  logic wr_q;
  logic [7:0] addr_q;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic sel_q;
  logic sel_d;
  logic [5:0] wen_q;
  logic [5:0] wen_d;
  logic [7:0] pen_q;
  logic [7:0] pen_d;
  logic [3:0] req_q;
  logic [3:0] req_d;
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic wr_d;
  logic [7:0] addr_d;
  logic rd_en;
  assign rd_en = hsel && hready && htrans[1] && !hwrite;
  always_comb
  begin
    wr_d = hsel && hready && htrans[1] && hwrite;
    addr_d = haddr;
    ctrl_d = ctrl_q;
    sel_d = sel_q;
    wen_d = wen_q;
    pen_d = pen_q;
    req_d = 4'h0;
    if (wr_q)
    begin
      case (addr_q)
        pmc_pkg::PMC_PWR_CTRL_OFS:
        begin
          ctrl_d = {hwdata[7:2], 2'b00};
          req_d[0] = hwdata[pmc_pkg::PMC_IDLE_BIT];
          req_d[1] = hwdata[pmc_pkg::PMC_STOP_BIT];
        end
        pmc_pkg::PMC_PWR_CTRL2_OFS:
        begin
          req_d[2] = hwdata[pmc_pkg::PMC_SUSPEND_BIT];
          req_d[3] = hwdata[pmc_pkg::PMC_SNOOZE_BIT];
        end
        pmc_pkg::PMC_REG_CTRL_OFS: sel_d = hwdata[pmc_pkg::PMC_STOPSEL_BIT];
        pmc_pkg::PMC_WAKE_EN_OFS: wen_d = hwdata[5:0];
        pmc_pkg::PMC_PERIPH_EN_OFS: pen_d = hwdata[7:0];
        default: sel_d = sel_q;
      endcase
    end
    rd_d = rd_q;
    if (rd_en)
    begin
      case (haddr)
        pmc_pkg::PMC_PWR_CTRL_OFS: rd_d = {24'h000000, ctrl_q};
        pmc_pkg::PMC_PWR_CTRL2_OFS: rd_d = 32'h00000000;
        pmc_pkg::PMC_REG_CTRL_OFS: rd_d = {31'h00000000, sel_q};
        pmc_pkg::PMC_STATUS_OFS: rd_d = {27'h0000000, lnk.cpu_halt, 1'b0, lnk.mode};
        pmc_pkg::PMC_WAKE_EN_OFS: rd_d = {26'h0000000, wen_q};
        pmc_pkg::PMC_PERIPH_EN_OFS: rd_d = {24'h000000, pen_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      ctrl_q <= pmc_pkg::PMC_PWR_CTRL_RST;
      sel_q <= 1'b0;
      wen_q <= 6'h00;
      pen_q <= pmc_pkg::PMC_PERIPH_EN_RST;
      req_q <= 4'h0;
      rd_q <= 32'h00000000;
    end
    else
    begin
      wr_q <= wr_d;
      addr_q <= addr_d;
      ctrl_q <= ctrl_d;
      sel_q <= sel_d;
      wen_q <= wen_d;
      pen_q <= pen_d;
      req_q <= req_d;
      rd_q <= rd_d;
    end
  end
  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign lnk.idle_req = req_q[0];
  assign lnk.stop_req = req_q[1];
  assign lnk.suspend_req = req_q[2];
  assign lnk.snooze_req = req_q[3];
  assign lnk.stop_shutdown_select = sel_q;
  assign lnk.wake_en = wen_q;
  assign lnk.periph_en = pen_q;
endmodule : pmc_core_regs
`default_nettype wire

// ### pmc_checker.sv
// Purpose: link checks between core end and sequencer end
// Assumes: one clock, mode codes as on the link
// Notes: normal is mode 0 with the core not halted
`timescale 1ns/100ps
`default_nettype none
module pmc_checker
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  input wire logic idle_req,
  input wire logic stop_req,
  input wire logic suspend_req,
  input wire logic snooze_req,
  input wire logic stop_shutdown_select,
  input wire logic cpu_halt,
  input wire logic idle_exit,
  input wire logic resume,
  input wire logic [2:0] mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic run;
  // warm-up also reads mode 0, so halt tells it apart
  assign run = (mode == 3'h0) && !cpu_halt;
  idle_entry_a: assert property (run && idle_req && !stop_req && !suspend_req
    && !snooze_req |=> mode == 3'h1 && cpu_halt) else $error("idle entry wrong");
  susp_entry_a: assert property (run && suspend_req && !snooze_req && !stop_req
    |=> mode == 3'h2) else $error("suspend entry wrong");
  snooze_entry_a: assert property (run && snooze_req && !stop_req
    |=> mode == 3'h3) else $error("snooze entry wrong");
  stop_entry_a: assert property (run && stop_req && !stop_shutdown_select
    |=> mode == 3'h4) else $error("stop entry wrong");
  shut_entry_a: assert property (run && stop_req && stop_shutdown_select
    |=> mode == 3'h5) else $error("shutdown entry wrong");
  stop_hold_a: assert property (mode == 3'h4 |=> mode inside {3'h4, 3'h0})
    else $error("stop left wrongly");
  shut_hold_a: assert property (mode == 3'h5 |=> mode inside {3'h5, 3'h0})
    else $error("shutdown left wrongly");
  halt_level_a: assert property (mode != 3'h0 |-> cpu_halt)
    else $error("core runs in low power");
  idle_exit_a: assert property (idle_exit |-> run && $past(mode) == 3'h1)
    else $error("idle exit wrong");
  resume_pulse_a: assert property (resume |-> !cpu_halt ##1 !resume)
    else $error("resume wrong");
  cover property (idle_exit);
  cover property (mode == 3'h3);
  cover property (mode == 3'h5);
endmodule : pmc_checker
`default_nettype wire

// ### test_power_mode_controller.sv
// Purpose: random and corner tests of both ends joined by the link
// Assumes: zero wait AHB slave, SETTLE_CYC shortened
// Notes: register reads go over the bus
`timescale 1ns/100ps
`default_nettype none
module test_power_mode_controller;
  localparam int SETTLE = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic irq = 1'b0;
  logic wdt = 1'b0;
  logic rpin_n = 1'b1;
  logic [5:0] wake = 6'h20;
  logic cclk, sclk, osca, oscb, lowb, ldo, rstq;
  logic t34, lfo, v5, hresp_s;
  logic [7:0] pclk;
  logic [15:0] fetch;
  logic [31:0] rd;
  logic [7:0] r8;
  int bad_count = 0;
  int check_count = 0;
  int n;
  always #5 hclk = ~hclk;
  pmc_if lnk ();
  pmc_core_regs pmc_core_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp_s), .lnk(lnk.core));
  pmc_sequencer #(.SETTLE_CYC(SETTLE)) pmc_sequencer_inst (.hclk(hclk), .hresetn(hresetn),
    .lnk(lnk.seq), .irq_pending(irq), .wdt_timeout(wdt), .reset_pin_n(rpin_n),
    .wake_evt(wake), .core_clk_en(cclk), .system_clock_en(sclk), .periph_clk_en(pclk),
    .fast_internal_osc_a_en(osca), .fast_internal_osc_b_en(oscb), .low_freq_osc_en(lfo),
    .timer34_lf_en(t34), .reg_low_bias(lowb), .core_ldo_en(ldo), .vreg5_active(v5),
    .sys_reset_req(rstq), .fetch_addr(fetch));
  pmc_checker pmc_checker_inst (.hclk(hclk), .hresetn(hresetn), .idle_req(lnk.idle_req),
    .stop_req(lnk.stop_req), .suspend_req(lnk.suspend_req), .snooze_req(lnk.snooze_req),
    .stop_shutdown_select(lnk.stop_shutdown_select), .cpu_halt(lnk.cpu_halt),
    .idle_exit(lnk.idle_exit), .resume(lnk.resume), .mode(lnk.mode));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // status word: halt flag in bit 4, mode code in bits 2:0
  function automatic logic [31:0] status_word(input logic [2:0] m, input logic h);
    return {27'h0, h, 1'b0, m};
  endfunction : status_word
  task automatic status(input logic [2:0] m, input logic h);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'h17, status_word(m, h));
  endtask : status
  // bounded wait, n returns the cycles spent
  task automatic halt_wait(input logic v);
    n = 0;
    while (lnk.cpu_halt !== v && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    chk(lnk.cpu_halt, v);
  endtask : halt_wait
  // returns mid-cycle so the one-cycle reset request is seen while it stands
  task automatic wdt_pulse;
    wdt <= 1'b1;
    @(posedge hclk);
    wdt <= 1'b0;
    @(negedge hclk);
  endtask : wdt_pulse
  initial
  begin
    n = $urandom(32'h7d41);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    status(3'h0, 1'b0);
    r8 = $urandom;
    bus(1'b1, 8'h00, {24'h0, r8[7:2], 2'h0});
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, {24'h0, r8[7:2], 2'h0});
    bus(1'b1, 8'h14, {24'h0, r8});
    repeat (2) @(posedge hclk);
    chk(pclk, r8);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(hresp_s, 1'b0);
    $display("done registers");
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h00, 32'h0);
    halt_wait(1'b1);
    status(3'h1, 1'b1);
    chk({cclk, sclk, pclk}, {2'h1, r8});
    bus(1'b0, 8'h00, 32'h0);
    chk(rd[1:0], 2'h0);
    irq <= 1'b1;
    halt_wait(1'b0);
    irq <= 1'b0;
    chk(cclk, 1'b1);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h00, 32'h0);
    halt_wait(1'b1);
    wdt_pulse();
    chk({rstq, lnk.mode, fetch}, 20'h80000);
    @(posedge hclk);
    $display("done idle");
    for (int i = 0; i < 6; i++)
    begin
      r8 = $urandom;
      repeat (4) @(posedge hclk);
      bus(1'b1, 8'h10, {26'h0, r8[5:0] | (6'h1 << i)});
      chk(osca, 1'b1);
      bus(1'b1, 8'h04, i[0] ? 32'h80 : 32'h40);
      halt_wait(1'b1);
      status(i[0] ? 3'h3 : 3'h2, 1'b1);
      chk({cclk, osca, oscb, lowb}, {3'h0, i[0]});
      chk({pclk, t34, lfo}, 10'h003);
      wake <= wake ^ (6'h1 << i);
      halt_wait(1'b0);
      chk(n > SETTLE, 1'b1);
      chk({cclk, osca, lowb, t34}, 4'hC);
      wake <= 6'h20;
    end
    $display("done suspend and snooze");
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h00, 32'h2);
    halt_wait(1'b1);
    status(3'h4, 1'b1);
    chk({ldo, v5}, 2'h3);
    wake <= 6'h01;
    irq <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(lnk.mode, 3'h4);
    wake <= 6'h20;
    irq <= 1'b0;
    wdt_pulse();
    chk({rstq, lnk.mode}, 4'h8);
    @(posedge hclk);
    halt_wait(1'b0);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h00, 32'h2);
    halt_wait(1'b1);
    status(3'h5, 1'b1);
    chk({ldo, v5}, 2'h1);
    wdt_pulse();
    chk(rstq, 1'b0);
    repeat (3) @(posedge hclk);
    chk(lnk.mode, 3'h5);
    rpin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    rpin_n <= 1'b1;
    halt_wait(1'b0);
    chk({lnk.mode, fetch}, 19'h0);
    $display("done stop and shutdown");
    finish_test();
  end
  initial
  begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule : test_power_mode_controller
`default_nettype wire
